// >>> shtu_level_sampler.sv
`timescale 1ns/10ps
module shtu_level_sampler (
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rst_n_i,
   // Analog sample and threshold
   input  wire logic [shtu_pkg::ADC_W-1:0]   adc_mv_i,
   input  wire logic [shtu_pkg::ADC_W-1:0]   thresh_mv_i,
   // Digital level and edges
   output logic                              level_o,
   output logic                              rise_o,
   output logic                              fall_o
);

   logic [shtu_pkg::ADC_W-1:0]        adc_meta_r;
   logic [shtu_pkg::ADC_W-1:0]        adc_sync_r;
   logic [shtu_pkg::ADC_W-1:0]        adc_prev_r;
   logic [shtu_pkg::SAMPLE_CNT_W-1:0] cnt_r;
   logic                              sample_en;
   logic                              level_nxt;

   // Two-flop synchroniser for the converter code, plus one older copy
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         adc_meta_r <= shtu_pkg::FULL_SCALE_MV;
         adc_sync_r <= shtu_pkg::FULL_SCALE_MV;
         adc_prev_r <= shtu_pkg::FULL_SCALE_MV;
      end else begin
         adc_meta_r <= adc_mv_i;
         adc_sync_r <= adc_meta_r;
         adc_prev_r <= adc_sync_r;
      end
   end

   // Sample interval divider
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= '0;
      end else if (sample_en) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign sample_en = (cnt_r == shtu_pkg::SAMPLE_CNT_W'(shtu_pkg::SAMPLE_CYCLES - 1));

   // Two consecutive codes must agree, so a torn multi-bit code cannot flip the level
   // Equal to threshold keeps the previous level, unless both codes are at full scale, which sets it high
   always_comb begin
      level_nxt = level_o;
      if ((adc_sync_r >= shtu_pkg::FULL_SCALE_MV) &&
          (adc_prev_r >= shtu_pkg::FULL_SCALE_MV)) begin
         level_nxt = 1'b1;
      end else if ((adc_sync_r > thresh_mv_i) && (adc_prev_r > thresh_mv_i)) begin
         level_nxt = 1'b1;
      end else if ((adc_sync_r < thresh_mv_i) && (adc_prev_r < thresh_mv_i)) begin
         level_nxt = 1'b0;
      end
   end

   // Level and edge detection across consecutive samples
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_o <= shtu_pkg::LEVEL_RST;
         rise_o  <= 1'b0;
         fall_o  <= 1'b0;
      end else begin
         rise_o <= sample_en && !level_o && level_nxt;
         fall_o <= sample_en && level_o && !level_nxt;
         if (sample_en) begin
            level_o <= level_nxt;
         end
      end
   end

endmodule

// >>> shtu_pkg.sv
package shtu_pkg;

   // Bus widths
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADC_W  = 12;

   // Register indices
   localparam logic [ADDR_W-1:0] REG_SCAN_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_SW_CTRL   = 4'h1;
   localparam logic [ADDR_W-1:0] REG_SW_CMD    = 4'h2;
   localparam logic [ADDR_W-1:0] REG_SW_STATE  = 4'h3;
   localparam logic [ADDR_W-1:0] REG_SW_FIRED  = 4'h4;
   localparam logic [ADDR_W-1:0] REG_THRESH    = 4'h5;
   localparam logic [ADDR_W-1:0] REG_LEVEL     = 4'h6;
   localparam logic [ADDR_W-1:0] REG_STATUS    = 4'h7;

   // Field positions
   localparam int unsigned EN_BIT     = 0;
   localparam int unsigned MODE_LSB   = 1;
   localparam int unsigned MODE_MSB   = 2;
   localparam int unsigned ARM_BIT    = 0;
   localparam int unsigned RESET_BIT  = 1;
   localparam int unsigned THR_DEF_BIT = 15;
   localparam int unsigned PEND_BIT   = 0;

   // Condition codes shared by scan gating and software trigger
   typedef enum logic [1:0] {
      SHTU_COND_LOW  = 2'h0,
      SHTU_COND_HIGH = 2'h1,
      SHTU_COND_RISE = 2'h2,
      SHTU_COND_FALL = 2'h3
   } shtu_cond_e;

   // Software trigger states, Gray along disabled-reset-armed-fired
   typedef enum logic [1:0] {
      SHTU_SW_DIS   = 2'h0,
      SHTU_SW_RST   = 2'h1,
      SHTU_SW_ARMED = 2'h3,
      SHTU_SW_FIRED = 2'h2
   } shtu_sw_e;

   // Reported state codes
   localparam logic [1:0] CODE_DIS   = 2'h0;
   localparam logic [1:0] CODE_RST   = 2'h1;
   localparam logic [1:0] CODE_ARMED = 2'h2;
   localparam logic [1:0] CODE_FIRED = 2'h3;

   // Threshold in millivolts
   localparam logic [ADC_W-1:0] THRESH_MAX_MV = 12'hce4;
   localparam logic [ADC_W-1:0] THRESH_DEF_MV = 12'h672;
   localparam logic [ADC_W-1:0] FULL_SCALE_MV = 12'hce4;

   // Sampling interval
   localparam int unsigned CLK_PERIOD_NS    = 10;
   localparam int unsigned SAMPLE_PERIOD_NS = 1000;
   localparam int unsigned SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned SAMPLE_CNT_W     = $clog2(SAMPLE_CYCLES);

   // Reset values
   localparam logic        LEVEL_RST  = 1'b1;
   localparam logic [1:0]  MODE_RST   = 2'h0;
   localparam logic        EN_RST     = 1'b0;

endpackage

// >>> shtu_top.sv
`timescale 1ns/10ps
module shtu_top (
   // Clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rst_n_i,
   // Register port
   input  wire logic [shtu_pkg::ADDR_W-1:0]   addr_i,
   input  wire logic [shtu_pkg::DATA_W-1:0]   wdata_i,
   input  wire logic                          wr_i,
   input  wire logic                          rd_i,
   output logic      [shtu_pkg::DATA_W-1:0]   rdata_o,
   // Trigger input converter code in millivolts
   input  wire logic [shtu_pkg::ADC_W-1:0]    trig_mv_i,
   // Scan request and start
   input  wire logic                          scan_req_i,
   output logic                               scan_start_o,
   output logic                               scan_pending_o,
   // Trigger status
   output logic                               trig_level_o,
   output logic                               sw_fired_o
);

   logic                            rst_meta_r;
   logic                            rst_sync_r;
   logic                            gate_en_r;
   shtu_pkg::shtu_cond_e            gate_mode_r;
   logic                            sw_en_r;
   shtu_pkg::shtu_cond_e            sw_mode_r;
   logic [shtu_pkg::ADC_W-1:0]      thresh_r;
   logic [shtu_pkg::ADC_W-1:0]      thresh_wr;
   shtu_pkg::shtu_sw_e              sw_state_r;
   shtu_pkg::shtu_sw_e              sw_state_nxt;
   logic [1:0]                      sw_code;
   logic                            pend_r;
   logic                            level;
   logic                            rise;
   logic                            fall;
   logic                            gate_met;
   logic                            sw_met;
   logic                            wr_scan;
   logic                            wr_swc;
   logic                            wr_cmd;
   logic                            wr_thr;
   logic                            arm_cmd;
   logic                            rst_cmd;
   logic [shtu_pkg::DATA_W-1:0]     rdata_nxt;

   // Reset release through two flops
   // Release is synchronous so no register leaves reset ahead of its neighbours
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // Trigger level sampler
   shtu_level_sampler u_sampler (
      .clk_i       (clk_i),
      .rst_n_i     (rst_sync_r),
      .adc_mv_i    (trig_mv_i),
      .thresh_mv_i (thresh_r),
      .level_o     (level),
      .rise_o      (rise),
      .fall_o      (fall)
   );

   // Write decode
   assign wr_scan = wr_i && (addr_i == shtu_pkg::REG_SCAN_CTRL);
   assign wr_swc  = wr_i && (addr_i == shtu_pkg::REG_SW_CTRL);
   assign wr_cmd  = wr_i && (addr_i == shtu_pkg::REG_SW_CMD);
   assign wr_thr  = wr_i && (addr_i == shtu_pkg::REG_THRESH);
   assign arm_cmd = wr_cmd && wdata_i[shtu_pkg::ARM_BIT];
   assign rst_cmd = wr_cmd && wdata_i[shtu_pkg::RESET_BIT];

   // Scan gating configuration
   always_ff @(posedge clk_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         gate_en_r   <= shtu_pkg::EN_RST;
         gate_mode_r <= shtu_pkg::shtu_cond_e'(shtu_pkg::MODE_RST);
      end else if (wr_scan) begin
         gate_en_r   <= wdata_i[shtu_pkg::EN_BIT];
         gate_mode_r <= shtu_pkg::shtu_cond_e'(
                        wdata_i[shtu_pkg::MODE_MSB:shtu_pkg::MODE_LSB]);
      end
   end

   // Software trigger configuration
   always_ff @(posedge clk_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         sw_en_r   <= shtu_pkg::EN_RST;
         sw_mode_r <= shtu_pkg::shtu_cond_e'(shtu_pkg::MODE_RST);
      end else if (wr_swc) begin
         sw_en_r   <= wdata_i[shtu_pkg::EN_BIT];
         sw_mode_r <= shtu_pkg::shtu_cond_e'(
                      wdata_i[shtu_pkg::MODE_MSB:shtu_pkg::MODE_LSB]);
      end
   end

   // Threshold: default request, clamp to full range
   always_comb begin
      if (wdata_i[shtu_pkg::THR_DEF_BIT]) begin
         thresh_wr = shtu_pkg::THRESH_DEF_MV;
      end else if (wdata_i[shtu_pkg::ADC_W-1:0] > shtu_pkg::THRESH_MAX_MV) begin
         thresh_wr = shtu_pkg::THRESH_MAX_MV;
      end else begin
         thresh_wr = wdata_i[shtu_pkg::ADC_W-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         thresh_r <= shtu_pkg::THRESH_DEF_MV;
      end else if (wr_thr) begin
         thresh_r <= thresh_wr;
      end
   end

   // Condition evaluation shared by both users
   function automatic logic cond_met(input shtu_pkg::shtu_cond_e mode,
                                     input logic lvl,
                                     input logic r,
                                     input logic f);
      logic met;
      met = 1'b0;
      unique case (mode)
         shtu_pkg::SHTU_COND_LOW:  met = !lvl;
         shtu_pkg::SHTU_COND_HIGH: met = lvl;
         shtu_pkg::SHTU_COND_RISE: met = r;
         shtu_pkg::SHTU_COND_FALL: met = f;
      endcase
      return met;
   endfunction

   assign gate_met = cond_met(gate_mode_r, level, rise, fall);
   assign sw_met   = cond_met(sw_mode_r, level, rise, fall);

   // Scan gating: pending hold and start pulse
   // Edges in the request cycle do not count; requests while pending are absorbed
   always_ff @(posedge clk_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         pend_r       <= 1'b0;
         scan_start_o <= 1'b0;
      end else begin
         scan_start_o <= 1'b0;
         if (!gate_en_r) begin
            pend_r <= 1'b0;
            if (scan_req_i || pend_r) begin
               scan_start_o <= 1'b1;
            end
         end else if (pend_r) begin
            if (gate_met) begin
               pend_r       <= 1'b0;
               scan_start_o <= 1'b1;
            end
         end else if (scan_req_i) begin
            if ((gate_mode_r == shtu_pkg::SHTU_COND_LOW) ||
                (gate_mode_r == shtu_pkg::SHTU_COND_HIGH)) begin
               if (gate_met) begin
                  scan_start_o <= 1'b1;
               end else begin
                  pend_r <= 1'b1;
               end
            end else begin
               pend_r <= 1'b1;
            end
         end
      end
   end

   assign scan_pending_o = pend_r;

   // Software trigger state machine
   always_comb begin
      sw_state_nxt = sw_state_r;
      if (!sw_en_r) begin
         sw_state_nxt = shtu_pkg::SHTU_SW_DIS;
      end else begin
         unique case (sw_state_r)
            shtu_pkg::SHTU_SW_DIS: begin
               if (arm_cmd) begin
                  sw_state_nxt = shtu_pkg::SHTU_SW_ARMED;
               end else begin
                  sw_state_nxt = shtu_pkg::SHTU_SW_RST;
               end
            end
            shtu_pkg::SHTU_SW_RST: begin
               if (arm_cmd) begin
                  sw_state_nxt = shtu_pkg::SHTU_SW_ARMED;
               end
            end
            shtu_pkg::SHTU_SW_ARMED: begin
               if (rst_cmd) begin
                  sw_state_nxt = shtu_pkg::SHTU_SW_RST;
               end else if (arm_cmd) begin
                  sw_state_nxt = shtu_pkg::SHTU_SW_ARMED;
               end else if (sw_met) begin
                  sw_state_nxt = shtu_pkg::SHTU_SW_FIRED;
               end
            end
            shtu_pkg::SHTU_SW_FIRED: begin
               if (rst_cmd) begin
                  sw_state_nxt = shtu_pkg::SHTU_SW_RST;
               end else if (arm_cmd) begin
                  sw_state_nxt = shtu_pkg::SHTU_SW_ARMED;
               end
            end
         endcase
         // Arm beats reset when both bits are written together
         if (rst_cmd && arm_cmd) begin
            sw_state_nxt = shtu_pkg::SHTU_SW_ARMED;
         end else if (rst_cmd && (sw_state_r != shtu_pkg::SHTU_SW_DIS)) begin
            sw_state_nxt = shtu_pkg::SHTU_SW_RST;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         sw_state_r <= shtu_pkg::SHTU_SW_DIS;
      end else begin
         sw_state_r <= sw_state_nxt;
      end
   end

   // Reported state code
   always_comb begin
      unique case (sw_state_r)
         shtu_pkg::SHTU_SW_DIS:   sw_code = shtu_pkg::CODE_DIS;
         shtu_pkg::SHTU_SW_RST:   sw_code = shtu_pkg::CODE_RST;
         shtu_pkg::SHTU_SW_ARMED: sw_code = shtu_pkg::CODE_ARMED;
         shtu_pkg::SHTU_SW_FIRED: sw_code = shtu_pkg::CODE_FIRED;
      endcase
   end

   assign sw_fired_o   = (sw_state_r == shtu_pkg::SHTU_SW_FIRED);
   assign trig_level_o = level;

   // Read mux
   // Unmapped and write-only indices read as zero
   always_comb begin
      rdata_nxt = '0;
      unique case (addr_i)
         shtu_pkg::REG_SCAN_CTRL: begin
            rdata_nxt[shtu_pkg::EN_BIT] = gate_en_r;
            rdata_nxt[shtu_pkg::MODE_MSB:shtu_pkg::MODE_LSB] = gate_mode_r;
         end
         shtu_pkg::REG_SW_CTRL: begin
            rdata_nxt[shtu_pkg::EN_BIT] = sw_en_r;
            rdata_nxt[shtu_pkg::MODE_MSB:shtu_pkg::MODE_LSB] = sw_mode_r;
         end
         shtu_pkg::REG_SW_STATE: begin
            rdata_nxt[1:0] = sw_code;
         end
         shtu_pkg::REG_SW_FIRED: begin
            rdata_nxt[0] = sw_fired_o;
         end
         shtu_pkg::REG_THRESH: begin
            rdata_nxt[shtu_pkg::ADC_W-1:0] = thresh_r;
         end
         shtu_pkg::REG_LEVEL: begin
            rdata_nxt[0] = level;
         end
         shtu_pkg::REG_STATUS: begin
            rdata_nxt[shtu_pkg::PEND_BIT] = pend_r;
         end
         default: begin
            rdata_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         rdata_o <= rdata_nxt;
      end else begin
         rdata_o <= '0;
      end
   end

endmodule

// >>> shtu_top_assertions.sv
`timescale 1ns/10ps
module shtu_top_checker (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic [3:0]  addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic [11:0] trig_mv_i,
   input wire logic        scan_req_i,
   input wire logic        scan_start_o,
   input wire logic        scan_pending_o,
   input wire logic        trig_level_o,
   input wire logic        sw_fired_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_start_clears: assert property (scan_start_o |-> !scan_pending_o)
      else $error("pending left set at scan start");
   a_pend_cause: assert property ($rose(scan_pending_o) |-> $past(scan_req_i))
      else $error("pending without a request");
   a_start_cause: assert property (scan_start_o |-> $past(scan_req_i) || $past(scan_pending_o))
      else $error("scan start without request or pending");
   a_pend_exit: assert property ($fell(scan_pending_o) |-> scan_start_o)
      else $error("pending dropped without start");
   a_level_hold: assert property ($changed(trig_level_o) |=> $stable(trig_level_o)[*8])
      else $error("level changed between samples");
   a_level_read: assert property ($past(rd_i) && $past(addr_i) == shtu_pkg::REG_LEVEL
      |-> rdata_o[0] == $past(trig_level_o)) else $error("level read mismatch");
   a_fired_read: assert property ($past(rd_i) && $past(addr_i) == shtu_pkg::REG_SW_FIRED
      |-> rdata_o[0] == $past(sw_fired_o)) else $error("fired read mismatch");
   a_state_read: assert property ($past(rd_i) && $past(addr_i) == shtu_pkg::REG_SW_STATE
      |-> (rdata_o[1:0] == shtu_pkg::CODE_FIRED) == $past(sw_fired_o))
      else $error("state read mismatch");
   a_fired_drop: assert property ($fell(sw_fired_o) |-> $past(wr_i) || $past(wr_i, 2))
      else $error("fired dropped without a write");
endmodule

bind shtu_top shtu_top_checker i_chk (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .trig_mv_i(trig_mv_i), .scan_req_i(scan_req_i),
   .scan_start_o(scan_start_o), .scan_pending_o(scan_pending_o),
   .trig_level_o(trig_level_o), .sw_fired_o(sw_fired_o));

// >>> shtu_top_tb.sv
`timescale 1ns/10ps
module shtu_top_tb;
   logic            clk_i;
   logic            rst_n_i;
   logic [3:0]      addr_i;
   logic [15:0]     wdata_i;
   logic            wr_i;
   logic            rd_i;
   logic [15:0]     rdata_o;
   logic [11:0]     trig_mv;
   logic            scan_req_i;
   logic            scan_start_o;
   logic            scan_pending_o;
   logic            trig_level_o;
   logic            sw_fired_o;
   logic            plugged;
   logic            high;
   int              error_cnt;
   int              cmp_count;
   int              cycles;
   int              m;
   logic [3:0][1:0] modes = 8'hc9;
   logic [3:0][1:0] smodes = 8'h78;
   logic [3:0]      d1 = 4'hc;

   shtu_trig_src i_src (.plugged_i(plugged), .high_i(high), .mv_o(trig_mv));
   shtu_top i_dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .trig_mv_i(trig_mv), .scan_req_i(scan_req_i),
      .scan_start_o(scan_start_o), .scan_pending_o(scan_pending_o),
      .trig_level_o(trig_level_o), .sw_fired_o(sw_fired_o));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, exp);
   endtask

   task automatic req_scan(input logic imm);
      @(posedge clk_i);
      scan_req_i <= 1'b1;
      @(posedge clk_i);
      scan_req_i <= 1'b0;
      #1;
      chk({14'h0, scan_start_o, scan_pending_o}, {14'h0, imm, !imm});
   endtask

   // Poll level (sel 0) or scan start (sel 1) at the falling edge
   task automatic wait_for(input logic sel, input logic v);
      int n;
      n = 0;
      while ((sel ? scan_start_o : trig_level_o) !== v && n < 300) begin
         @(negedge clk_i);
         n++;
      end
      chk({15'h0, (sel ? scan_start_o : trig_level_o)}, {15'h0, v});
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         final_report();
      end
   end

   initial begin
      rst_n_i    = 1'b0;
      addr_i     = 4'h0;
      wdata_i    = 16'h0000;
      wr_i       = 1'b0;
      rd_i       = 1'b0;
      scan_req_i = 1'b0;
      plugged    = 1'b0;
      high       = 1'b1;
      cycles     = 0;
      error_cnt  = 0;
      cmp_count  = 0;
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(shtu_pkg::REG_LEVEL, 16'h0001);
      rd(shtu_pkg::REG_THRESH, 16'h0672);
      rd(shtu_pkg::REG_SW_STATE, 16'h0000);
      rd(shtu_pkg::REG_SCAN_CTRL, 16'h0000);
      rd(4'hf, 16'h0000);
      $display("test reset done");
      plugged <= 1'b1;
      wr(shtu_pkg::REG_THRESH, 16'h0fff);
      rd(shtu_pkg::REG_THRESH, 16'h0ce4);
      wr(shtu_pkg::REG_THRESH, 16'h0bb9);
      wait_for(1'b0, 1'b0);
      rd(shtu_pkg::REG_LEVEL, 16'h0000);
      wr(shtu_pkg::REG_THRESH, 16'h8000);
      rd(shtu_pkg::REG_THRESH, 16'h0672);
      wait_for(1'b0, 1'b1);
      $display("test threshold done");
      req_scan(1'b1);
      for (m = 0; m < 4; m++) begin
         wr(shtu_pkg::REG_SCAN_CTRL, {13'h0, modes[m], 1'b1});
         rd(shtu_pkg::REG_SCAN_CTRL, {13'h0, modes[m], 1'b1});
         req_scan(m == 0);
         if (m != 0) begin
            high <= d1[m];
            wait_for(1'b0, d1[m]);
            chk({15'h0, scan_pending_o}, 16'h0001);
            rd(shtu_pkg::REG_STATUS, 16'h0001);
            high <= !d1[m];
            wait_for(1'b1, 1'b1);
         end
      end
      req_scan(1'b0);
      wr(shtu_pkg::REG_SCAN_CTRL, 16'h0000);
      wait_for(1'b1, 1'b1);
      $display("test scan gating done");
      wr(shtu_pkg::REG_SW_CMD, 16'h0001);
      rd(shtu_pkg::REG_SW_STATE, 16'h0000);
      for (m = 0; m < 4; m++) begin
         wr(shtu_pkg::REG_SW_CTRL, {13'h0, smodes[m], 1'b1});
         wr(shtu_pkg::REG_SW_CMD, 16'h0002);
         repeat (2) @(posedge clk_i);
         rd(shtu_pkg::REG_SW_CTRL, {13'h0, smodes[m], 1'b1});
         rd(shtu_pkg::REG_SW_STATE, 16'h0001);
         rd(shtu_pkg::REG_SW_FIRED, 16'h0000);
         chk({15'h0, sw_fired_o}, 16'h0000);
         wr(shtu_pkg::REG_SW_CMD, 16'h0001);
         rd(shtu_pkg::REG_SW_STATE, m == 0 ? 16'h0003 : 16'h0002);
         if (m != 0) begin
            high <= smodes[m][0] ^ smodes[m][1];
            wait_for(1'b0, smodes[m][0] ^ smodes[m][1]);
            repeat (3) @(posedge clk_i);
            rd(shtu_pkg::REG_SW_STATE, 16'h0003);
         end
         rd(shtu_pkg::REG_SW_FIRED, 16'h0001);
         chk({15'h0, sw_fired_o}, 16'h0001);
      end
      wr(shtu_pkg::REG_SW_CTRL, 16'h0000);
      repeat (2) @(posedge clk_i);
      wr(shtu_pkg::REG_SW_CMD, 16'h0001);
      rd(shtu_pkg::REG_SW_STATE, 16'h0000);
      rd(shtu_pkg::REG_SW_CTRL, 16'h0000);
      $display("test software trigger done");
      final_report();
   end
endmodule

// >>> shtu_trig_src.sv
`timescale 1ns/10ps
module shtu_trig_src (
   // Line control from the bench
   input  wire logic        plugged_i,
   input  wire logic        high_i,
   // Converter code in millivolts
   output logic      [11:0] mv_o
);
   // Open input floats up to full scale, driven line sits far from the default threshold
   assign mv_o = !plugged_i ? shtu_pkg::FULL_SCALE_MV : (high_i ? 12'hbb8 : 12'h0c8);
endmodule
